// >>> dv/ctcp_mem_model.sv
// Partner model: host memory serving control bytes
`timescale 1ns/1ps
module ctcp_mem_model (
  // Clock and answer delay
  input wire logic        clk,
  input wire logic [3:0]  lat,
  // Fetch bus
  input wire logic        direct_memory_request,
  input wire logic [17:0] dm_addr,
  output logic            dm_ack,
  output logic [7:0]      dm_rdata
);
  logic [7:0]  mem [logic [17:0]];
  logic [17:0] last_addr = '0;
  int          wait_cnt;
  int          fetch_cnt;
  initial dm_ack = 1'b0;
  initial dm_rdata = 8'hA5;
  // One ack per request; idle data toggles so stale bytes look wrong
  always @(posedge clk) begin
    if (direct_memory_request && !dm_ack && wait_cnt >= int'(lat)) begin
      dm_ack <= 1'b1;
      dm_rdata <= mem[dm_addr];
      last_addr <= dm_addr;
      fetch_cnt <= fetch_cnt + 1;
      wait_cnt <= 0;
    end else begin
      dm_ack <= 1'b0;
      dm_rdata <= ~dm_rdata;
      if (direct_memory_request && !dm_ack) wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : ctcp_mem_model

// >>> dv/ctcp_top_checker.sv
// Checker: port-level assertions on the character processor
`timescale 1ns/1ps
module ctcp_top_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Character handshakes
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        tx_ready,
  input wire logic        rx_attention,
  input wire logic        rx_store_valid,
  input wire logic        tx_out_valid,
  input wire logic        tx_out_ready,
  input wire logic [7:0]  tx_out_char,
  input wire logic        tx_block_end,
  // Memory bus
  input wire logic        direct_memory_request,
  input wire logic [17:0] dm_addr,
  input wire logic        dm_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_REQ_HOLD: assert property (
    direct_memory_request && !dm_ack |=> direct_memory_request && $stable(dm_addr))
    else $error("request moved before ack");
  AST_ACK_DROP: assert property (
    direct_memory_request && dm_ack |=> !direct_memory_request)
    else $error("request held after ack");
  AST_BUSY: assert property (
    direct_memory_request |-> !rx_ready && !tx_ready)
    else $error("char offered in fetch");
  AST_RX_PRIO: assert property (rx_valid |-> !tx_ready)
    else $error("tx over pending rx");
  AST_ATTN_WAIT: assert property (
    rx_attention |-> !rx_store_valid && !rx_ready)
    else $error("progress awaiting host");
  AST_STORE_PULSE: assert property (rx_store_valid |=> !rx_store_valid)
    else $error("store pulse too long");
  AST_OUT_HOLD: assert property (
    tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_char))
    else $error("stalled char changed");
  AST_BLK_END: assert property (
    tx_block_end |-> $past(tx_out_valid && tx_out_ready))
    else $error("block end untaken");
  // Main scenarios reached
  COV_STORE: cover property (rx_store_valid);
  COV_ATTN: cover property ($rose(rx_attention));
  COV_TX_END: cover property (tx_block_end);
endmodule : ctcp_top_checker

bind ctcp_top ctcp_top_checker ctcp_top_checker_i (.clk(clk), .sys_rst(sys_rst),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_ready(tx_ready),
  .rx_attention(rx_attention), .rx_store_valid(rx_store_valid),
  .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_out_char(tx_out_char),
  .tx_block_end(tx_block_end), .direct_memory_request(direct_memory_request),
  .dm_addr(dm_addr), .dm_ack(dm_ack));

// >>> dv/ctcp_top_tb.sv
// Testbench: scenarios for the character processor
`timescale 1ns/1ps
module ctcp_top_tb;
  import ctcp_pkg::*;
  localparam logic [1:0] EX = 2'b01;
  localparam logic [15:0] BR = 16'h0800;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rx_valid = 0, tx_valid = 0;
  logic tx_out_ready = 0, rx_attention, rx_ready, rx_store_valid, rx_block_end;
  logic rx_bcc_error, tx_ready, tx_out_valid, tx_block_end, dmr, dm_ack;
  logic [7:0] reg_addr = 0, rx_char = 0, tx_char = 0, rx_store_char, tx_out_char, dm_rdata;
  logic [31:0] reg_wdata = 0, reg_rdata, v;
  logic [3:0] rx_line = 4'h2, tx_line = 4'h2, lat = 0, rx_store_line, tx_out_line;
  logic [17:0] dm_addr;
  logic [7:0] st_c, txq[$];
  int st_n, be_n, er_n, tb_n, cyc, err_total, check_count;
  ctcp_top #(.NUM_LINES(16)) ctcp_top_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_attention(rx_attention), .rx_valid(rx_valid), .rx_line(rx_line), .rx_char(rx_char),
    .rx_ready(rx_ready), .rx_store_valid(rx_store_valid), .rx_store_line(rx_store_line),
    .rx_store_char(rx_store_char), .rx_block_end(rx_block_end), .rx_bcc_error(rx_bcc_error),
    .tx_valid(tx_valid), .tx_line(tx_line), .tx_char(tx_char), .tx_ready(tx_ready),
    .tx_out_valid(tx_out_valid), .tx_out_line(tx_out_line), .tx_out_char(tx_out_char),
    .tx_out_ready(tx_out_ready), .tx_block_end(tx_block_end), .direct_memory_request(dmr),
    .dm_addr(dm_addr), .dm_ack(dm_ack), .dm_rdata(dm_rdata));
  ctcp_mem_model ctcp_mem_model_i (.clk(clk), .lat(lat), .direct_memory_request(dmr),
    .dm_addr(dm_addr), .dm_ack(dm_ack), .dm_rdata(dm_rdata));
  always #5 clk = ~clk;
  // Sink stalls every other cycle; count pulses
  always @(posedge clk) begin
    tx_out_ready <= ~tx_out_ready;
    cyc++;
    if (rx_store_valid === 1'b1) st_n++;
    if (rx_store_valid === 1'b1) st_c = rx_store_char;
    if (rx_block_end === 1'b1) be_n++;
    if (rx_bcc_error === 1'b1) er_n++;
    if (tx_block_end === 1'b1) tb_n++;
    if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1) txq.push_back(tx_out_char);
    if (cyc == 4000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Data stand the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic rxc(input logic [7:0] c, input bit wt);
    rx_char <= c;
    rx_valid <= 1'b1;
    do @(posedge clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    @(posedge clk);
    while (wt && rx_ready !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : rxc
  task automatic t_store();
    rxc(8'h41, 1);
    chk("fetch addr", {EX, BR + 16'h0041}, ctcp_mem_model_i.last_addr);
    chk("stored", 8'h41, st_c);
    rd(CTCP_OFS_MODES);
    chk("rx mode", 32'h2, v);
  endtask : t_store
  task automatic t_intr();
    lat <= 4'h3;
    rxc(8'h41, 0);
    while (rx_attention !== 1'b1) @(posedge clk);
    chk("mode addr", {EX, BR + 16'h0241}, ctcp_mem_model_i.last_addr);
    rd(CTCP_OFS_RX_INT);
    chk("int char", 32'h141, v);
    chk("held", 1, st_n);
    wr(CTCP_OFS_SPECIAL, 32'h10);
    repeat (6) @(posedge clk);
    chk("special store", 2, st_n);
  endtask : t_intr
  task automatic t_expect();
    rxc(8'h03, 1);
    chk("block end", 1, be_n);
    chk("discard", 2, st_n);
    rd(CTCP_OFS_RX_BCC);
    chk("rx check", 32'h42, v);
    rxc(8'h42, 1);
    chk("check ok", 0, er_n + st_n - 2);
  endtask : t_expect
  task automatic t_tx();
    tx_char <= 8'h55;
    tx_valid <= 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    while (tb_n == 0) @(posedge clk);
    chk("tx seq", 24'h105555, {txq[0], txq[1], txq[2]});
    chk("tx addr", {EX, 16'h0A55}, ctcp_mem_model_i.last_addr);
    rd(CTCP_OFS_MODES);
    chk("tx mode", 32'h30, v);
  endtask : t_tx
  task automatic t_inh();
    wr(CTCP_OFS_PARAMS, 32'h110);
    rxc(8'h77, 1);
    chk("no fetch", 4, ctcp_mem_model_i.fetch_cnt);
    chk("inh store", 8'h77, st_c);
  endtask : t_inh
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Tables: store to mode 2, interrupt, expect check, DLE+check
  initial begin
    ctcp_mem_model_i.mem[{EX, 16'h0841}] = 8'h32;
    ctcp_mem_model_i.mem[{EX, 16'h0A41}] = 8'h08;
    ctcp_mem_model_i.mem[{EX, 16'h0803}] = 8'h60;
    ctcp_mem_model_i.mem[{EX, 16'h0A55}] = 8'h3B;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wr(CTCP_OFS_LINE_SEL, 32'h2);
    wr(CTCP_OFS_RX_BASE, {16'h0, BR});
    wr(CTCP_OFS_TX_BASE, 32'h0A00);
    wr(CTCP_OFS_EXT, {30'h0, EX});
    t_store();
    t_intr();
    lat <= 4'h0;
    t_expect();
    t_tx();
    t_inh();
    summarize();
  end
endmodule : ctcp_top_tb

// >>> rtl/ctcp_fetch.sv
// Direct memory request master that reads one control byte per request
`timescale 1ns/1ps
module ctcp_fetch
  import ctcp_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Sequencer side
  ctcp_fetch_if.mstr                  fif,
  // Memory bus side
  output logic                        direct_memory_request,
  output logic [ctcp_pkg::CTCP_ADDR_W-1:0] dm_addr,
  input  wire logic                   dm_ack,
  input  wire logic [7:0]             dm_rdata
);

  // ----------------------------------------------------------------
  // Request holds until the memory answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      direct_memory_request <= 1'b0;
      dm_addr               <= '0;
    end else if (direct_memory_request && dm_ack) begin
      direct_memory_request <= 1'b0;
    end else if (fif.start && !direct_memory_request) begin
      direct_memory_request <= 1'b1;
      dm_addr               <= fif.addr;
    end
  end

  // Data taken at the acknowledge, done one cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fif.done <= 1'b0;
      fif.data <= 8'h00;
    end else begin
      fif.done <= direct_memory_request && dm_ack;
      if (direct_memory_request && dm_ack) begin
        fif.data <= dm_rdata;
      end
    end
  end

endmodule : ctcp_fetch

// >>> rtl/ctcp_fetch_if.sv
// Interface: control byte fetch request between sequencer and bus master
`timescale 1ns/1ps
interface ctcp_fetch_if;
  logic                          start;  // One-cycle fetch request
  logic [ctcp_pkg::CTCP_ADDR_W-1:0] addr;
  logic                          done;   // One-cycle fetch completion
  logic [7:0]                    data;

  modport ctrl (output start, output addr, input done, input data);
  modport mstr (input start, input addr, output done, output data);
endinterface : ctcp_fetch_if

// >>> rtl/ctcp_pkg.sv
// Package: constants shared by the control table character processor
package ctcp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CTCP_CHAR_W  = 8;
  localparam int CTCP_MODE_W  = 3;
  localparam int CTCP_BASE_W  = 16;
  localparam int CTCP_EXT_W   = 2;
  localparam int CTCP_ADDR_W  = 18;
  localparam int CTCP_REG_AW  = 8;
  localparam int CTCP_MODE_LSB = 8;   // Mode lands on address bits 8..10

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTCP_OFS_LINE_SEL = 8'h00;
  localparam logic [7:0] CTCP_OFS_RX_BASE  = 8'h04;
  localparam logic [7:0] CTCP_OFS_TX_BASE  = 8'h08;
  localparam logic [7:0] CTCP_OFS_EXT      = 8'h0C;
  localparam logic [7:0] CTCP_OFS_PARAMS   = 8'h10;
  localparam logic [7:0] CTCP_OFS_MODES    = 8'h14;
  localparam logic [7:0] CTCP_OFS_RX_BCC   = 8'h18;
  localparam logic [7:0] CTCP_OFS_TX_BCC   = 8'h1C;
  localparam logic [7:0] CTCP_OFS_RX_INT   = 8'h20;
  localparam logic [7:0] CTCP_OFS_SPECIAL  = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTCP_PRM_RX_INH = 8;   // Params: DLE in 7:0
  localparam int CTCP_PRM_TX_INH = 9;
  localparam int CTCP_MODES_TX   = 4;   // Modes: rx in 2:0, tx in 6:4
  localparam int CTCP_RIC_PEND   = 8;   // Interrupt char reg: char 7:0
  localparam int CTCP_RCB_INT    = 3;   // Receive control byte
  localparam int CTCP_RCB_STORE  = 4;
  localparam int CTCP_RCB_ACC    = 5;
  localparam int CTCP_RCB_EXPECT = 6;
  localparam int CTCP_TCB_ACC    = 3;   // Transmit control byte
  localparam int CTCP_TCB_SENDBCC = 4;
  localparam int CTCP_TCB_DLE    = 5;

  // ----------------------------------------------------------------
  // Values after reset and fixed bytes used under fetch inhibit
  // ----------------------------------------------------------------
  localparam logic [7:0] CTCP_RX_INHIBIT_CB = 8'h30;  // Mode 0, store, accumulate
  localparam logic [7:0] CTCP_TX_INHIBIT_CB = 8'h08;  // Mode 0, accumulate
  localparam logic [7:0] CTCP_DLE_RESET     = 8'h10;
  localparam logic [2:0] CTCP_MODE_RESET    = 3'h0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CTCP_IDLE, CTCP_RX_FETCH, CTCP_RX_APPLY, CTCP_RX_HOST,
    CTCP_TX_FETCH, CTCP_TX_DLE, CTCP_TX_CHAR, CTCP_TX_BCC
  } ctcp_state_e;

endpackage : ctcp_pkg

// >>> rtl/ctcp_top.sv
// Control table character processor: per-character control byte sequencer
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Every character gets one fetched control byte, except an expected check and an inhibited mode 0 character
// - Address is table base plus character code
// - Each mode region spans 256 byte entries
// - Separate 3-bit rx and tx mode per line
// - Mode added at address bits 8..10
// - Control byte sets the line's next mode
// - Received character fetches by direct memory request
// - Interrupt loads character, signals host
// - Store or discard received character
// - Accumulate received character into check or not
// - Expect-check makes next character the check
// - Check anticipation starts receive block termination
// - Host special byte replaces fetched dispositions
// - Fetch precedes sending each character not inhibited in mode 0
// - Accumulate transmitted character into check or not
// - Send check after character, end block
// - Send stored DLE immediately before character
// - Two extended bits make 18-bit fetch address
// - Inhibit in mode 0 skips fetch, stores, accumulates
module ctcp_top
  import ctcp_pkg::*;
#(
  parameter int NUM_LINES = 16
)(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // Register port
  input  wire logic [ctcp_pkg::CTCP_REG_AW-1:0] reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [31:0]                      reg_rdata,
  // Host attention for receive interrupt
  output logic                             rx_attention,
  // Receiver character input
  input  wire logic                        rx_valid,
  input  wire logic [$clog2(NUM_LINES)-1:0] rx_line,
  input  wire logic [7:0]                  rx_char,
  output logic                             rx_ready,
  // Receive results
  output logic                             rx_store_valid,
  output logic [$clog2(NUM_LINES)-1:0]     rx_store_line,
  output logic [7:0]                       rx_store_char,
  output logic                             rx_block_end,
  output logic                             rx_bcc_error,
  // Transmit character from memory
  input  wire logic                        tx_valid,
  input  wire logic [$clog2(NUM_LINES)-1:0] tx_line,
  input  wire logic [7:0]                  tx_char,
  output logic                             tx_ready,
  // Transmitter output
  output logic                             tx_out_valid,
  output logic [$clog2(NUM_LINES)-1:0]     tx_out_line,
  output logic [7:0]                       tx_out_char,
  input  wire logic                        tx_out_ready,
  output logic                             tx_block_end,
  // Memory bus
  output logic                             direct_memory_request,
  output logic [ctcp_pkg::CTCP_ADDR_W-1:0] dm_addr,
  input  wire logic                        dm_ack,
  input  wire logic [7:0]                  dm_rdata
);

  localparam int LW = $clog2(NUM_LINES);

  // ----------------------------------------------------------------
  // Per-line storage
  // ----------------------------------------------------------------
  logic [CTCP_BASE_W-1:0] rx_base_reg [NUM_LINES];
  logic [CTCP_BASE_W-1:0] tx_base_reg [NUM_LINES];
  logic [CTCP_EXT_W-1:0]  ext_reg     [NUM_LINES];
  logic [7:0]             dle_reg     [NUM_LINES];
  logic                   rx_inh_reg  [NUM_LINES];
  logic                   tx_inh_reg  [NUM_LINES];
  logic [CTCP_MODE_W-1:0] rx_mode_reg [NUM_LINES];
  logic [CTCP_MODE_W-1:0] tx_mode_reg [NUM_LINES];
  logic [7:0]             rx_bcc_reg  [NUM_LINES];
  logic [7:0]             tx_bcc_reg  [NUM_LINES];
  logic                   expect_reg  [NUM_LINES];

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  ctcp_state_e     st_reg;
  logic [LW-1:0]   line_reg;
  logic [LW-1:0]   sel_reg;
  logic [7:0]      char_reg;
  logic [7:0]      cb_reg;
  logic [7:0]      ric_reg;
  logic            ric_pend_reg;
  logic [7:0]      special_reg;
  logic            special_hit;
  logic            wr_sel;

  ctcp_fetch_if fif ();

  // Bus master for control byte reads
  ctcp_fetch u_fetch (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .fif                   (fif.mstr),
    .direct_memory_request (direct_memory_request),
    .dm_addr               (dm_addr),
    .dm_ack                (dm_ack),
    .dm_rdata              (dm_rdata)
  );

  // ----------------------------------------------------------------
  // Control byte address formation
  // ----------------------------------------------------------------
  function automatic logic [CTCP_ADDR_W-1:0] cb_addr(
    input logic [CTCP_EXT_W-1:0]  ext,
    input logic [CTCP_BASE_W-1:0] base,
    input logic [CTCP_MODE_W-1:0] mode,
    input logic [7:0]             chr
  );
    logic [CTCP_BASE_W-1:0] sum;
    // Sum wraps in 16 bits, ext bits are appended not added
    sum = base + {8'h00, chr};
    sum = sum + (CTCP_BASE_W'(mode) << CTCP_MODE_LSB);
    return {ext, sum};
  endfunction : cb_addr

  // Receive wins over transmit when both arrive together
  assign rx_ready = (st_reg == CTCP_IDLE);
  assign tx_ready = (st_reg == CTCP_IDLE) && !rx_valid;
  assign rx_attention = ric_pend_reg;
  assign special_hit  = reg_wr && (reg_addr == CTCP_OFS_SPECIAL) && (st_reg == CTCP_RX_HOST);
  assign wr_sel       = reg_wr && (reg_addr == CTCP_OFS_LINE_SEL);

  // ----------------------------------------------------------------
  // Host configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_reg <= '0;
      for (int i = 0; i < NUM_LINES; i++) begin
        rx_base_reg[i] <= '0;
        tx_base_reg[i] <= '0;
        ext_reg[i]     <= '0;
        dle_reg[i]     <= CTCP_DLE_RESET;
        rx_inh_reg[i]  <= 1'b0;
        tx_inh_reg[i]  <= 1'b0;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        CTCP_OFS_LINE_SEL: sel_reg <= reg_wdata[LW-1:0];
        CTCP_OFS_RX_BASE:  rx_base_reg[sel_reg] <= reg_wdata[CTCP_BASE_W-1:0];
        CTCP_OFS_TX_BASE:  tx_base_reg[sel_reg] <= reg_wdata[CTCP_BASE_W-1:0];
        CTCP_OFS_EXT:      ext_reg[sel_reg] <= reg_wdata[CTCP_EXT_W-1:0];
        CTCP_OFS_PARAMS: begin
          dle_reg[sel_reg]    <= reg_wdata[7:0];
          rx_inh_reg[sel_reg] <= reg_wdata[CTCP_PRM_RX_INH];
          tx_inh_reg[sel_reg] <= reg_wdata[CTCP_PRM_TX_INH];
        end
        default: ;
      endcase
    end
  end

  // Host may preset a mode; sequencer update wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        rx_mode_reg[i] <= CTCP_MODE_RESET;
        tx_mode_reg[i] <= CTCP_MODE_RESET;
      end
    end else begin
      if (reg_wr && reg_addr == CTCP_OFS_MODES) begin
        rx_mode_reg[sel_reg] <= reg_wdata[CTCP_MODE_W-1:0];
        tx_mode_reg[sel_reg] <= reg_wdata[CTCP_MODES_TX +: CTCP_MODE_W];
      end
      if (st_reg == CTCP_RX_APPLY) begin
        rx_mode_reg[line_reg] <= cb_reg[CTCP_MODE_W-1:0];
      end
      if (st_reg == CTCP_TX_FETCH && fif.done) begin
        tx_mode_reg[line_reg] <= fif.data[CTCP_MODE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg    <= CTCP_IDLE;
      line_reg  <= '0;
      char_reg  <= 8'h00;
      cb_reg    <= 8'h00;
      fif.start <= 1'b0;
      fif.addr  <= '0;
    end else begin
      fif.start <= 1'b0;
      case (st_reg)
        CTCP_IDLE: begin
          if (rx_valid) begin
            line_reg <= rx_line;
            char_reg <= rx_char;
            if (expect_reg[rx_line]) begin
              st_reg <= CTCP_IDLE;
            end else if (rx_inh_reg[rx_line] && rx_mode_reg[rx_line] == 3'h0) begin
              cb_reg <= CTCP_RX_INHIBIT_CB;
              st_reg <= CTCP_RX_APPLY;
            end else begin
              fif.start <= 1'b1;
              fif.addr  <= cb_addr(ext_reg[rx_line], rx_base_reg[rx_line],
                                   rx_mode_reg[rx_line], rx_char);
              st_reg    <= CTCP_RX_FETCH;
            end
          end else if (tx_valid) begin
            line_reg  <= tx_line;
            char_reg  <= tx_char;
            if (tx_inh_reg[tx_line] && tx_mode_reg[tx_line] == 3'h0) begin
              cb_reg <= CTCP_TX_INHIBIT_CB;
              st_reg <= CTCP_TX_CHAR;
            end else begin
              fif.start <= 1'b1;
              fif.addr  <= cb_addr(ext_reg[tx_line], tx_base_reg[tx_line],
                                   tx_mode_reg[tx_line], tx_char);
              st_reg    <= CTCP_TX_FETCH;
            end
          end
        end
        CTCP_RX_FETCH: begin
          if (fif.done) begin
            cb_reg <= fif.data;
            // Interrupt character waits for the host
            st_reg <= fif.data[CTCP_RCB_INT] ? CTCP_RX_HOST : CTCP_RX_APPLY;
          end
        end
        CTCP_RX_HOST: begin
          if (special_hit) begin
            // Keep fetched mode, host gives dispositions
            cb_reg <= {reg_wdata[7:CTCP_MODE_W], cb_reg[CTCP_MODE_W-1:0]};
            st_reg <= CTCP_RX_APPLY;
          end
        end
        CTCP_RX_APPLY: st_reg <= CTCP_IDLE;
        CTCP_TX_FETCH: begin
          if (fif.done) begin
            cb_reg <= fif.data;
            st_reg <= fif.data[CTCP_TCB_DLE] ? CTCP_TX_DLE : CTCP_TX_CHAR;
          end
        end
        CTCP_TX_DLE: begin
          if (tx_out_ready) begin
            st_reg <= CTCP_TX_CHAR;
          end
        end
        CTCP_TX_CHAR: begin
          if (tx_out_ready) begin
            st_reg <= cb_reg[CTCP_TCB_SENDBCC] ? CTCP_TX_BCC : CTCP_IDLE;
          end
        end
        CTCP_TX_BCC: begin
          if (tx_out_ready) begin
            st_reg <= CTCP_IDLE;
          end
        end
        default: st_reg <= CTCP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit output: DLE, char, check, each held until taken
  // ----------------------------------------------------------------
  assign tx_out_valid = (st_reg == CTCP_TX_DLE) || (st_reg == CTCP_TX_CHAR) ||
                        (st_reg == CTCP_TX_BCC);
  assign tx_out_line  = line_reg;
  always_comb begin
    case (st_reg)
      CTCP_TX_DLE: tx_out_char = dle_reg[line_reg];
      CTCP_TX_BCC: tx_out_char = tx_bcc_reg[line_reg];
      default:     tx_out_char = char_reg;
    endcase
  end

  // ----------------------------------------------------------------
  // Block check accumulators, expectation flags and block ends
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_block_end <= 1'b0;
      tx_block_end <= 1'b0;
      rx_bcc_error <= 1'b0;
      for (int i = 0; i < NUM_LINES; i++) begin
        rx_bcc_reg[i] <= 8'h00;
        tx_bcc_reg[i] <= 8'h00;
        expect_reg[i] <= 1'b0;
      end
    end else begin
      rx_block_end <= 1'b0;
      tx_block_end <= 1'b0;
      rx_bcc_error <= 1'b0;
      // Check character closes block, restarts accumulation
      if (st_reg == CTCP_IDLE && rx_valid && expect_reg[rx_line]) begin
        rx_bcc_error          <= (rx_char != rx_bcc_reg[rx_line]);
        rx_bcc_reg[rx_line]   <= 8'h00;
        expect_reg[rx_line]   <= 1'b0;
      end
      if (st_reg == CTCP_RX_APPLY) begin
        if (cb_reg[CTCP_RCB_ACC]) begin
          rx_bcc_reg[line_reg] <= rx_bcc_reg[line_reg] ^ char_reg;
        end
        if (cb_reg[CTCP_RCB_EXPECT]) begin
          expect_reg[line_reg] <= 1'b1;
          rx_block_end         <= 1'b1;
        end
      end
      if (st_reg == CTCP_TX_CHAR && tx_out_ready && cb_reg[CTCP_TCB_ACC]) begin
        tx_bcc_reg[line_reg] <= tx_bcc_reg[line_reg] ^ char_reg;
      end
      if (st_reg == CTCP_TX_BCC && tx_out_ready) begin
        tx_bcc_reg[line_reg] <= 8'h00;
        tx_block_end         <= 1'b1;
      end
      if (reg_wr && reg_addr == CTCP_OFS_RX_BCC) begin
        rx_bcc_reg[sel_reg] <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == CTCP_OFS_TX_BCC) begin
        tx_bcc_reg[sel_reg] <= reg_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive store path and interrupt character register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_store_valid <= 1'b0;
      rx_store_line  <= '0;
      rx_store_char  <= 8'h00;
    end else begin
      rx_store_valid <= (st_reg == CTCP_RX_APPLY) && cb_reg[CTCP_RCB_STORE];
      rx_store_line  <= line_reg;
      rx_store_char  <= char_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ric_reg      <= 8'h00;
      ric_pend_reg <= 1'b0;
      special_reg  <= 8'h00;
    end else begin
      if (st_reg == CTCP_RX_FETCH && fif.done && fif.data[CTCP_RCB_INT]) begin
        ric_reg      <= char_reg;
        ric_pend_reg <= 1'b1;
      end else if (special_hit) begin
        ric_pend_reg <= 1'b0;
        special_reg  <= reg_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read, data the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        CTCP_OFS_LINE_SEL: reg_rdata <= 32'(sel_reg);
        CTCP_OFS_RX_BASE:  reg_rdata <= 32'(rx_base_reg[sel_reg]);
        CTCP_OFS_TX_BASE:  reg_rdata <= 32'(tx_base_reg[sel_reg]);
        CTCP_OFS_EXT:      reg_rdata <= 32'(ext_reg[sel_reg]);
        CTCP_OFS_PARAMS:   reg_rdata <= 32'({tx_inh_reg[sel_reg], rx_inh_reg[sel_reg],
                                             dle_reg[sel_reg]});
        CTCP_OFS_MODES:    reg_rdata <= 32'({1'b0, tx_mode_reg[sel_reg],
                                             1'b0, rx_mode_reg[sel_reg]});
        CTCP_OFS_RX_BCC:   reg_rdata <= 32'(rx_bcc_reg[sel_reg]);
        CTCP_OFS_TX_BCC:   reg_rdata <= 32'(tx_bcc_reg[sel_reg]);
        CTCP_OFS_RX_INT:   reg_rdata <= 32'({ric_pend_reg, ric_reg});
        CTCP_OFS_SPECIAL:  reg_rdata <= 32'(special_reg);
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : ctcp_top
